//--- rtl/sap_len_check.sv
`timescale 1ns/1ns
`default_nettype none
module sap_len_check
  import sap_pkg::*;
#(
  parameter int W         = LEN_W,
  parameter int FAULT_RUN = 1
) (
  input  wire logic         core_clk,
  input  wire logic         srst,
  input  wire logic         clk_en,
  input  wire logic         meas_valid,
  input  wire logic [W-1:0] meas_len,
  input  wire logic [W-1:0] expect_len,
  output logic              fault
);

  localparam int CW = $clog2(FAULT_RUN + 1);
  localparam logic [CW-1:0] RUN_LAST = CW'(FAULT_RUN - 1);
  localparam logic [CW-1:0] RUN_ZERO = '0;
  localparam logic [CW-1:0] RUN_ONE  = CW'(1);

  logic [CW-1:0] run_cnt;
  logic          mismatch;

  assign mismatch = meas_valid && (meas_len != expect_len);

  // a matching measurement breaks the run of mismatches
  always_ff @(posedge core_clk) begin
    if (srst) begin
      run_cnt <= RUN_ZERO;
    end else if (clk_en && meas_valid) begin
      if (!mismatch) begin
        run_cnt <= RUN_ZERO;
      end else if (run_cnt != RUN_LAST) begin
        run_cnt <= run_cnt + RUN_ONE;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      fault <= 1'b0;
    end else if (clk_en) begin
      fault <= mismatch && (run_cnt == RUN_LAST);
    end
  end

  chk_fault_on_run: assert property (
    @(posedge core_clk) disable iff (srst)
    clk_en && mismatch && run_cnt == RUN_LAST |=> fault)
    else $error("length fault missing after mismatch run");

  chk_no_early_fault: assert property (
    @(posedge core_clk) disable iff (srst)
    $rose(fault) |-> $past(run_cnt) == RUN_LAST && $past(mismatch))
    else $error("length fault raised before the run completed");

endmodule
`default_nettype wire

//--- rtl/sap_pkg.sv
package sap_pkg;

  // width of a measured timing length, in pixel-clock counts
  localparam int LEN_W = 16;
  // consecutive mismatches that make a timing fault
  localparam int DE_FAULT_RUN = 1;
  localparam int VS_FAULT_RUN = 2;

  // shared pin positions within the pin vector
  localparam int PIN_W            = 10;
  localparam int IO_MASTER_SERIAL = 0;
  localparam int IO_MASTER_WORD   = 1;
  localparam int IO_SLAVE_DATA_C  = 2;
  localparam int IO_SLAVE_DATA_D  = 3;
  localparam int IO_SLAVE_DATA_B  = 5;
  localparam int IO_SLAVE_DATA_A  = 6;
  localparam int IO_SLAVE_WORD    = 7;
  localparam int IO_SLAVE_BIT     = 8;
  localparam int IO_MASTER_SYS    = 9;

  // register-only pins: always driven, low after reset
  localparam logic [PIN_W-1:0] REG_ONLY_MASK = 10'h1e0;
  localparam logic [PIN_W-1:0] PIN_LEVEL_RST = 10'h000;
  localparam logic [PIN_W-1:0] PIN_OE_RST    = 10'h1e0;

  typedef struct packed {
    logic       word_clk;
    logic       bit_clk;
    logic [3:0] data;      // [0]=A .. [3]=D
  } sap_slave_aud_s;

  typedef struct packed {
    logic word_clk;
    logic serial_out;
    logic sys_clk;
  } sap_master_aud_s;

  typedef struct packed {
    logic [PIN_W-1:0] level;
    logic [PIN_W-1:0] oe;
  } sap_pins_s;

  typedef enum logic [1:0] {
    ST_NORMAL_OK    = 2'b00,
    ST_NORMAL_FAULT = 2'b01,
    ST_SELF_TEST    = 2'b10
  } sap_pass_state_e;

endpackage

//--- rtl/sap_status_pins.sv
`timescale 1ns/1ns
`default_nettype none
// Operation
// - lock output high while PLL locked and camera outputs active, else low.
// - with self-test off, pass output stays high while no timing fault seen.
// - in normal mode one data-enable length mismatch drives pass low.
// - two consecutive vsync length mismatches drive pass low; one does not.
// - with self-test on, pass shows self-test result: high ok, low error.
// - slave audio enable puts word, bit clock, data A-D on shared pins.
// - master audio enable puts word clock, serial out, system clock on pins.
// - register-only pins always drive their gpio level when not used for audio.
module sap_status_pins
  import sap_pkg::*;
(
  input  wire logic            core_clk,
  input  wire logic            srst,
  input  wire logic            clk_en,
  input  wire logic            pll_locked,
  input  wire logic            camera_serial_physical_outputs,
  input  wire logic            self_test_enable_input,
  input  wire logic            self_test_error,
  input  wire logic            de_meas_valid,
  input  wire logic [LEN_W-1:0] de_meas_len,
  input  wire logic [LEN_W-1:0] de_expect_len,
  input  wire logic            vs_meas_valid,
  input  wire logic [LEN_W-1:0] vs_meas_len,
  input  wire logic [LEN_W-1:0] vs_expect_len,
  input  wire logic            fault_clear,
  input  wire logic            slave_audio_en,
  input  wire logic            master_audio_en,
  input  wire sap_slave_aud_s  slave_audio,
  input  wire sap_master_aud_s master_audio,
  input  wire sap_pins_s       gpio_drive,
  output logic                 lock_status,
  output logic                 pass_status,
  output sap_pins_s            pins
);

  logic            test_pin_meta;
  logic            self_test_mode;
  logic            de_fault;
  logic            vs_fault;
  sap_pass_state_e pass_state;
  sap_pass_state_e next_pass_state;
  sap_pins_s       next_pins;

  // the self-test pin is a board strap/pin, so it is synchronised first
  always_ff @(posedge core_clk) begin
    if (srst) begin
      test_pin_meta  <= 1'b0;
      self_test_mode <= 1'b0;
    end else if (clk_en) begin
      test_pin_meta  <= self_test_enable_input;
      self_test_mode <= test_pin_meta;
    end
  end

  // lock needs both PLL lock and live camera outputs
  always_ff @(posedge core_clk) begin
    if (srst) begin
      lock_status <= 1'b0;
    end else if (clk_en) begin
      lock_status <= pll_locked && camera_serial_physical_outputs;
    end
  end

  sap_len_check #(
    .W         (LEN_W),
    .FAULT_RUN (DE_FAULT_RUN)
  ) u_de_check (
    .core_clk   (core_clk),
    .srst       (srst),
    .clk_en     (clk_en),
    .meas_valid (de_meas_valid),
    .meas_len   (de_meas_len),
    .expect_len (de_expect_len),
    .fault      (de_fault)
  );

  sap_len_check #(
    .W         (LEN_W),
    .FAULT_RUN (VS_FAULT_RUN)
  ) u_vs_check (
    .core_clk   (core_clk),
    .srst       (srst),
    .clk_en     (clk_en),
    .meas_valid (vs_meas_valid),
    .meas_len   (vs_meas_len),
    .expect_len (vs_expect_len),
    .fault      (vs_fault)
  );

  // a timing fault is sticky; a fault arriving with the clear still wins
  always_comb begin
    next_pass_state = pass_state;
    case (pass_state)
      ST_NORMAL_OK: begin
        if (self_test_mode) begin
          next_pass_state = ST_SELF_TEST;
        end else if (de_fault || vs_fault) begin
          next_pass_state = ST_NORMAL_FAULT;
        end
      end
      ST_NORMAL_FAULT: begin
        if (self_test_mode) begin
          next_pass_state = ST_SELF_TEST;
        end else if (fault_clear && !de_fault && !vs_fault) begin
          next_pass_state = ST_NORMAL_OK;
        end
      end
      ST_SELF_TEST: begin
        // leaving self-test returns pass to ST_NORMAL_OK; the length checkers keep their run counts
        if (!self_test_mode) begin
          next_pass_state = ST_NORMAL_OK;
        end
      end
      default: begin
        next_pass_state = ST_NORMAL_OK;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      pass_state <= ST_NORMAL_OK;
    end else if (clk_en) begin
      pass_state <= next_pass_state;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      pass_status <= 1'b1;
    end else if (clk_en) begin
      case (next_pass_state)
        ST_SELF_TEST:    pass_status <= !self_test_error;
        ST_NORMAL_FAULT: pass_status <= 1'b0;
        default:         pass_status <= 1'b1;
      endcase
    end
  end

  // pin multiplexer: gpio by default, audio functions override their pins
  always_comb begin
    next_pins       = gpio_drive;
    // register-only pins are never left floating
    next_pins.oe    = gpio_drive.oe | REG_ONLY_MASK;
    if (slave_audio_en) begin
      next_pins.level[IO_SLAVE_WORD]   = slave_audio.word_clk;
      next_pins.level[IO_SLAVE_BIT]    = slave_audio.bit_clk;
      next_pins.level[IO_SLAVE_DATA_A] = slave_audio.data[0];
      next_pins.level[IO_SLAVE_DATA_B] = slave_audio.data[1];
      next_pins.level[IO_SLAVE_DATA_C] = slave_audio.data[2];
      next_pins.level[IO_SLAVE_DATA_D] = slave_audio.data[3];
      next_pins.oe[IO_SLAVE_WORD]      = 1'b1;
      next_pins.oe[IO_SLAVE_BIT]       = 1'b1;
      next_pins.oe[IO_SLAVE_DATA_A]    = 1'b1;
      next_pins.oe[IO_SLAVE_DATA_B]    = 1'b1;
      next_pins.oe[IO_SLAVE_DATA_C]    = 1'b1;
      next_pins.oe[IO_SLAVE_DATA_D]    = 1'b1;
    end
    if (master_audio_en) begin
      next_pins.level[IO_MASTER_WORD]   = master_audio.word_clk;
      next_pins.level[IO_MASTER_SERIAL] = master_audio.serial_out;
      next_pins.level[IO_MASTER_SYS]    = master_audio.sys_clk;
      next_pins.oe[IO_MASTER_WORD]      = 1'b1;
      next_pins.oe[IO_MASTER_SERIAL]    = 1'b1;
      next_pins.oe[IO_MASTER_SYS]       = 1'b1;
    end
  end

  // registered pins add one cycle of latency to audio clocks; the audio
  // source must run well below core_clk / 2
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pins.level <= PIN_LEVEL_RST;
      pins.oe    <= PIN_OE_RST;
    end else if (clk_en) begin
      pins <= next_pins;
    end
  end

  chk_lock_high: assert property (
    @(posedge core_clk) disable iff (srst)
    clk_en && pll_locked && camera_serial_physical_outputs |=> lock_status)
    else $error("lock not raised while locked and active");

  chk_lock_low: assert property (
    @(posedge core_clk) disable iff (srst)
    clk_en && !pll_locked |=> !lock_status)
    else $error("lock stayed high while unlocked");

  chk_pass_idle_high: assert property (
    @(posedge core_clk) disable iff (srst)
    clk_en && pass_state == ST_NORMAL_OK && !self_test_mode
      && !de_fault && !vs_fault |=> pass_status)
    else $error("pass low without a timing fault");

  chk_de_fault_pass: assert property (
    @(posedge core_clk) disable iff (srst)
    clk_en && !self_test_mode && pass_state != ST_SELF_TEST
      && de_fault |=> !pass_status ##1 (!pass_status
      || $past(fault_clear) || $past(self_test_mode)))
    else $error("pass not held low after data-enable fault");

  chk_vs_fault_pass: assert property (
    @(posedge core_clk) disable iff (srst)
    clk_en && !self_test_mode && pass_state != ST_SELF_TEST
      && vs_fault |=> !pass_status)
    else $error("pass not low after vsync fault");

  chk_self_test_pass: assert property (
    @(posedge core_clk) disable iff (srst)
    clk_en && self_test_mode |=> pass_status == !$past(self_test_error))
    else $error("pass does not show self-test result");

  chk_slave_audio_pins: assert property (
    @(posedge core_clk) disable iff (srst)
    clk_en && slave_audio_en |=> pins.oe[IO_SLAVE_WORD]
      && pins.oe[IO_SLAVE_DATA_D]
      && pins.level[IO_SLAVE_WORD] == $past(slave_audio.word_clk)
      && pins.level[IO_SLAVE_DATA_D] == $past(slave_audio.data[3]))
    else $error("slave audio not routed to pins");

  chk_master_audio_pins: assert property (
    @(posedge core_clk) disable iff (srst)
    clk_en && master_audio_en |=> pins.oe[IO_MASTER_SYS]
      && pins.level[IO_MASTER_SERIAL] == $past(master_audio.serial_out)
      && pins.level[IO_MASTER_SYS] == $past(master_audio.sys_clk))
    else $error("master audio not routed to pins");

  chk_reg_pin_default: assert property (
    @(posedge core_clk) disable iff (srst)
    clk_en && !slave_audio_en |=> pins.oe[IO_SLAVE_WORD]
      && pins.level[IO_SLAVE_WORD] == $past(gpio_drive.level[IO_SLAVE_WORD]))
    else $error("register-only pin not driven from gpio value");

endmodule
`default_nettype wire

//--- tb/sap_audio_partner.sv
`timescale 1ns/1ns
`default_nettype none
module sap_audio_partner
  import sap_pkg::*;
(
  input  wire logic      core_clk,
  input  wire logic      srst,
  input  wire logic      want_slave,
  output logic           slave_audio_en,
  output sap_slave_aud_s slave_audio,
  output logic [7:0]     aud_ctrl
);
  logic [5:0] phase;
  // cleaner goes off a cycle before slave audio is routed, never after
  always_ff @(posedge core_clk) begin
    if (srst) begin
      aud_ctrl       <= 8'h00;
      slave_audio_en <= 1'b0;
    end else begin
      if (want_slave) aud_ctrl[7] <= 1'b1;
      slave_audio_en <= want_slave && aud_ctrl[7];
    end
  end
  always_ff @(posedge core_clk) begin
    if (srst) phase <= 6'h00;
    else phase <= phase + 6'h01;
  end
  assign slave_audio = {phase[0], phase[1], phase[5:2]};
endmodule
`default_nettype wire

//--- tb/tb_status_and_audio_pin_select.sv
`timescale 1ns/1ns
`default_nettype none
module tb_status_and_audio_pin_select;
  import sap_pkg::*;
  logic            core_clk = 0, srst = 1, clk_en = 1;
  logic            pll_locked = 0, cam = 0, ste = 0, ste_err = 0;
  logic            de_v = 0, vs_v = 0, fclr = 0, m_en = 0, want_slave = 0;
  logic [15:0]     de_len = 0, vs_len = 0;
  logic [15:0]     de_exp = 16'h0780, vs_exp = 16'h0005;
  sap_master_aud_s maud = 3'h0;
  sap_pins_s       gdrv = 20'h04010;
  logic            lock_status, pass_status, s_en;
  sap_pins_s       pins;
  sap_slave_aud_s  saud, sa;
  logic [7:0]      aud_ctrl;
  int              num_errors = 0, total_checks = 0, cycles = 0;

  sap_status_pins dut_u (.core_clk(core_clk), .srst(srst), .clk_en(clk_en),
    .pll_locked(pll_locked), .camera_serial_physical_outputs(cam),
    .self_test_enable_input(ste), .self_test_error(ste_err),
    .de_meas_valid(de_v), .de_meas_len(de_len), .de_expect_len(de_exp),
    .vs_meas_valid(vs_v), .vs_meas_len(vs_len), .vs_expect_len(vs_exp),
    .fault_clear(fclr), .slave_audio_en(s_en), .master_audio_en(m_en),
    .slave_audio(saud), .master_audio(maud), .gpio_drive(gdrv),
    .lock_status(lock_status), .pass_status(pass_status), .pins(pins));
  sap_audio_partner far_u (.core_clk(core_clk), .srst(srst),
    .want_slave(want_slave), .slave_audio_en(s_en), .slave_audio(saud),
    .aud_ctrl(aud_ctrl));

  always #5 core_clk = ~core_clk;

  task final_report;
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // run is about 150 cycles; the ceiling leaves ample room
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      final_report;
    end
  end

  task chk(input logic [19:0] got, input logic [19:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task meas(input logic vs, input logic [15:0] len);
    @(posedge core_clk);
    if (vs) begin
      vs_v   <= 1'b1;
      vs_len <= len;
    end else begin
      de_v   <= 1'b1;
      de_len <= len;
    end
    @(posedge core_clk);
    vs_v <= 1'b0;
    de_v <= 1'b0;
  endtask

  task clear_fault;
    @(posedge core_clk);
    fclr <= 1'b1;
    @(posedge core_clk);
    fclr <= 1'b0;
    tick(2);
  endtask

  function automatic sap_pins_s exp_pins(sap_slave_aud_s s, logic sen,
                                         sap_master_aud_s m, logic men);
    sap_pins_s p = gdrv;
    p.oe = p.oe | REG_ONLY_MASK;
    if (sen) begin
      p.level[IO_SLAVE_WORD]   = s.word_clk;
      p.level[IO_SLAVE_BIT]    = s.bit_clk;
      p.level[IO_SLAVE_DATA_A] = s.data[0];
      p.level[IO_SLAVE_DATA_B] = s.data[1];
      p.level[IO_SLAVE_DATA_C] = s.data[2];
      p.level[IO_SLAVE_DATA_D] = s.data[3];
      p.oe = p.oe | 10'h1ec;
    end
    if (men) begin
      p.level[IO_MASTER_WORD]   = m.word_clk;
      p.level[IO_MASTER_SERIAL] = m.serial_out;
      p.level[IO_MASTER_SYS]    = m.sys_clk;
      p.oe = p.oe | 10'h203;
    end
    return p;
  endfunction

  task run_pins(input logic men, input logic sen);
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk);
      m_en <= men;
      maud <= i[2:0];
      #1 sa = saud;
      tick(1);
      chk(pins, exp_pins(sa, sen, i[2:0], men));
    end
  endtask

  initial begin
    tick(16);
    chk({lock_status, pass_status}, 2'b01);
    chk(pins, 20'h001e0);
    @(posedge core_clk);
    srst <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      {pll_locked, cam} <= i[1:0];
      tick(1);
      chk(lock_status, i == 3);
    end
    // with the enable low the lock flop must hold through an unlock
    @(posedge core_clk);
    clk_en     <= 1'b0;
    pll_locked <= 1'b0;
    tick(3);
    chk(lock_status, 1'b1);
    @(posedge core_clk);
    clk_en <= 1'b1;
    tick(1);
    chk(lock_status, 1'b0);
    $display("test lock done");
    meas(1, vs_exp + 16'h0001);
    tick(3);
    chk(pass_status, 1'b1);
    meas(1, vs_exp);
    meas(1, vs_exp + 16'h0001);
    tick(3);
    chk(pass_status, 1'b1);
    meas(1, vs_exp - 16'h0001);
    tick(2);
    chk(pass_status, 1'b0);
    clear_fault;
    meas(0, de_exp);
    meas(0, de_exp);
    tick(3);
    chk(pass_status, 1'b1);
    meas(0, de_exp - 16'h0001);
    tick(2);
    chk(pass_status, 1'b0);
    // a new fault in the same cycle as the clear must keep pass low
    @(posedge core_clk);
    de_v   <= 1'b1;
    de_len <= de_exp + 16'h0002;
    @(posedge core_clk);
    de_v <= 1'b0;
    fclr <= 1'b1;
    @(posedge core_clk);
    fclr <= 1'b0;
    tick(2);
    chk(pass_status, 1'b0);
    clear_fault;
    chk(pass_status, 1'b1);
    $display("test timing done");
    @(posedge core_clk);
    ste <= 1'b1;
    tick(4);
    chk(pass_status, 1'b1);
    @(posedge core_clk);
    ste_err <= 1'b1;
    tick(2);
    chk(pass_status, 1'b0);
    @(posedge core_clk);
    ste_err <= 1'b0;
    meas(0, 16'h0000);
    tick(3);
    chk(pass_status, 1'b1);
    @(posedge core_clk);
    ste <= 1'b0;
    tick(5);
    chk(pass_status, 1'b1);
    $display("test self test done");
    @(posedge core_clk);
    want_slave <= 1'b1;
    tick(3);
    chk(aud_ctrl[7], 1'b1);
    run_pins(1'b0, 1'b1);
    run_pins(1'b1, 1'b1);
    @(posedge core_clk);
    want_slave <= 1'b0;
    tick(3);
    run_pins(1'b0, 1'b0);
    $display("test pins done");
    final_report;
  end
endmodule
`default_nettype wire
